// *** bench/pls_angle_source.sv ***
// Master angle bus model driving both buses with position steps.
`timescale 1ns/100ps
`default_nettype none
module pls_angle_source (
    input  wire logic               clk,
    input  wire logic               go,
    input  wire logic [7:0]         steps,
    input  wire logic signed [15:0] da,
    input  wire logic signed [15:0] db,
    output logic                    busy,
    output logic signed [15:0]      delta_a,
    output logic signed [15:0]      delta_b,
    output logic                    strobe_a,
    output logic                    strobe_b
);
    logic [9:0] left = 10'h000;
    wire        fire = busy && left[1:0] == 2'b01;
    initial {strobe_a, strobe_b, delta_a, delta_b} = 34'h0;
    assign busy = left != 10'h000;
    // Data lines invert between strobes so a stale sample cannot pass.
    always @(posedge clk) begin
        left <= go ? {steps, 2'b00} : busy ? left - 10'h001 : left;
        strobe_a <= fire;
        strobe_b <= fire;
        delta_a <= fire ? da : ~delta_a;
        delta_b <= fire ? db : ~delta_b;
    end
endmodule // pls_angle_source
`default_nettype wire

// *** bench/pls_controller_assertions.sv ***
// Concurrent checks on the limit switch controller ports.
`timescale 1ns/100ps
`default_nettype none
module pls_checker #(
    parameter int POS_W = 24
) (
    input wire logic             CLK_SYS,
    input wire logic             RST_N,
    input wire logic             ANGLE_STROBE_A,
    input wire logic             ANGLE_STROBE_B,
    input wire logic             SET_CYCLE,
    input wire logic             PRESET,
    input wire logic [POS_W-1:0] PRESET_VALUE,
    input wire logic             READ_POS,
    input wire logic             TABLE_WRITE,
    input wire logic             ADV_WRITE,
    input wire logic [POS_W-1:0] POS_READ,
    input wire logic             POS_VALID,
    input wire logic [15:0]      HW_OUT,
    input wire logic [7:0]       SW_FLAG,
    input wire logic [3:0]       SW_IRQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [5:0] quiet;
    wire calm = !(ANGLE_STROBE_A | ANGLE_STROBE_B | SET_CYCLE | PRESET);
    // Quiet counts cycles with nothing that may move the outputs; only valid while advance stays zero.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N || !calm || TABLE_WRITE || ADV_WRITE)
            quiet <= 6'h00;
        else if (quiet != 6'h3f)
            quiet <= quiet + 6'h01;
    end
    sequence s_preset;
        PRESET && PRESET_VALUE < 'h2000;
    endsequence
    sequence s_calm_read;
        READ_POS && calm;
    endsequence
    chk_valid_after_read: assert property (READ_POS |=> POS_VALID)
        else $error("no valid after read");
    chk_valid_cause: assert property (POS_VALID |-> $past(READ_POS))
        else $error("valid without read");
    chk_read_holds: assert property (!READ_POS |=> $stable(POS_READ))
        else $error("read value moved");
    chk_preset_load: assert property (s_preset ##1 s_calm_read |=> POS_READ == $past(PRESET_VALUE, 2))
        else $error("preset not loaded");
    chk_read_steady: assert property (s_calm_read ##1 s_calm_read |=> POS_READ == $past(POS_READ))
        else $error("read altered position");
    chk_irq_pulse: assert property (SW_IRQ != 4'h0 |=> (SW_IRQ & $past(SW_IRQ)) == 4'h0)
        else $error("interrupt longer than a pulse");
    chk_reset_clear: assert property ($rose(RST_N) |-> HW_OUT == 16'h0 && SW_FLAG == 8'h0 && !POS_VALID)
        else $error("outputs not clear after reset");
    chk_outputs_quiet: assert property (quiet > 6'h2f |-> $stable(HW_OUT) && $stable(SW_FLAG) && SW_IRQ == 4'h0)
        else $error("outputs moved while idle");
endmodule // pls_checker
bind pls_controller pls_checker #(.POS_W(POS_W)) chk (.*);
`default_nettype wire

// *** bench/programmable_limit_switch_test.sv ***
// Self-checking bench for the programmable limit switch controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module programmable_limit_switch_test;
    logic CLK_SYS = 1'b0, RST_N = 1'b0, BUS_SELECT = 1'b0, SET_CYCLE = 1'b0, PRESET = 1'b0, READ_POS = 1'b0;
    logic TABLE_WRITE = 1'b0, ADV_WRITE = 1'b0, go = 1'b0, busy, ANGLE_STROBE_A, ANGLE_STROBE_B, POS_VALID;
    logic [23:0] CYCLE_VALUE = 24'h0, PRESET_VALUE = 24'h0, TABLE_DATA = 24'h0, POS_READ, len = 24'h2000, v;
    logic [12:0] TABLE_ADDR = 13'h0;
    logic [2:0] ADV_SEL = 3'h0;
    logic [7:0] ADV_VALUE = 8'h0, steps = 8'h0, SW_FLAG;
    logic signed [15:0] ANGLE_DELTA_A, ANGLE_DELTA_B, da = 16'sh0, db = 16'sh0;
    logic [15:0] HW_OUT;
    logic [3:0] SW_IRQ;
    int seed = 46799, n_errors = 0, tests_run = 0, i, k;
    always #5 CLK_SYS = ~CLK_SYS;
    pls_controller dut (.*);
    pls_angle_source far (.clk(CLK_SYS), .go(go), .steps(steps), .da(da), .db(db), .busy(busy),
        .delta_a(ANGLE_DELTA_A), .delta_b(ANGLE_DELTA_B), .strobe_a(ANGLE_STROBE_A), .strobe_b(ANGLE_STROBE_B));
    function automatic logic [23:0] entry(input logic [12:0] a);
        return {a[7:0] ^ 8'h5a, a, a[2:0]};
    endfunction
    function automatic logic [23:0] wrap(input logic [23:0] p, input int d);
        longint t;
        t = (longint'(p) + d + longint'(len)) % longint'(len);
        return t[23:0];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic preset(input logic [23:0] p);
        PRESET_VALUE <= p;
        PRESET <= 1'b1;
        tick(1);
        PRESET <= 1'b0;
        READ_POS <= 1'b1;
        tick(1);
        READ_POS <= 1'b0;
    endtask
    // Two back-to-back reads after the outputs settle, then table lookup compared.
    task automatic check(input logic [23:0] p);
        logic [23:0] e;
        e = entry(13'((48'(p) * 48'h2000) / 48'(len)));
        tick(40);
        READ_POS <= 1'b1;
        tick(2);
        READ_POS <= 1'b0;
        @(negedge CLK_SYS);
        `CHK(POS_VALID, 1'b1)
        `CHK(POS_READ, p)
        `CHK(HW_OUT, e[15:0])
        `CHK(SW_FLAG, e[23:16])
        tick(1);
    endtask
    initial begin
        tick(60000);
        n_errors++;
        stop_test();
    end
    initial begin
        tick(20);
        RST_N <= 1'b1;
        tick(1);
        for (i = 0; i < 8192; i++) begin
            TABLE_WRITE <= 1'b1;
            TABLE_ADDR <= 13'(i);
            TABLE_DATA <= entry(13'(i));
            tick(1);
        end
        TABLE_WRITE <= 1'b0;
        for (i = 0; i < 8; i++) begin
            ADV_WRITE <= 1'b1;
            ADV_SEL <= 3'(i);
            tick(1);
        end
        ADV_WRITE <= 1'b0;
        check(24'h0);
        for (k = 0; k < 4; k++) begin
            len = (k == 0) ? 24'h014000 : (k == 1) ? 24'h002000 : 24'h002000 + 24'($random(seed) & 32'h7ffff);
            CYCLE_VALUE <= len;
            SET_CYCLE <= 1'b1;
            tick(1);
            CYCLE_VALUE <= 24'h0;
            tick(1);
            SET_CYCLE <= 1'b0;
            for (i = 0; i < 4; i++) begin
                v = (i == 0) ? len - 24'h1 : (i == 1) ? len : 24'($unsigned($random(seed)) % len);
                preset(v);
                check((v < len) ? v : 24'h0);
            end
        end
        for (k = 0; k < 2; k++) begin
            BUS_SELECT <= k[0];
            v = (k == 1) ? 24'h000005 : len - 24'h28;
            preset(v);
            da <= 16'(($random(seed) % 100) + 100);
            db <= 16'(($random(seed) % 100) - 100);
            steps <= 8'h09;
            go <= 1'b1;
            tick(1);
            go <= 1'b0;
            tick(2);
            for (i = 0; i < 100 && busy; i++)
                tick(1);
            if (busy) begin
                n_errors++;
                stop_test();
            end
            check(wrap(v, 9 * ((k == 1) ? int'(db) : int'(da))));
        end
        stop_test();
    end
endmodule // programmable_limit_switch_test
`default_nettype wire

// *** verilog/pls_controller.sv ***
// Programmable limit switch: position accumulator, switching table and outputs.
//
// How it works
// [RQ1] Accumulate selected bus position changes up to cycle length.
// [RQ2] Source select picks one of two angle buses.
// [RQ3] Host-programmed cycle length limits the accumulator.
// [RQ4] Host scales angles to the cycle length.
// [RQ5] Table of 8192 entries holds every output state.
// [RQ6] Outputs on between programmed on and off angles.
// [RQ7] Preset command loads the accumulator.
// [RQ8] Readback returns accumulator without changing it.
// [RQ9] Sixteen hardware switch outputs.
// [RQ10] Eight polling flags, four raise interrupts.
// [RQ11] Position rolls over at the programmed cycle point.
// [RQ12] Eight outputs get 0 to 2.55 s advance.
// [RQ13] Outputs update within 1.5 ms of crossing.
// [RQ14] Advanced outputs update within 10 ms.
// [RQ15] Accumulator scaled to index 0 to 8191.
`timescale 1ns/100ps
`default_nettype none
module pls_controller #(
    parameter int POS_W = pls_pkg::POS_W
) (
    input  wire logic                        CLK_SYS,
    input  wire logic                        RST_N,
    input  wire logic                        BUS_SELECT,
    input  wire logic signed [15:0]          ANGLE_DELTA_A,
    input  wire logic                        ANGLE_STROBE_A,
    input  wire logic signed [15:0]          ANGLE_DELTA_B,
    input  wire logic                        ANGLE_STROBE_B,
    input  wire logic                        SET_CYCLE,
    input  wire logic [POS_W-1:0]            CYCLE_VALUE,
    input  wire logic                        PRESET,
    input  wire logic [POS_W-1:0]            PRESET_VALUE,
    input  wire logic                        READ_POS,
    input  wire logic                        TABLE_WRITE,
    input  wire logic [12:0]                 TABLE_ADDR,
    input  wire logic [23:0]                 TABLE_DATA,
    input  wire logic                        ADV_WRITE,
    input  wire logic [2:0]                  ADV_SEL,
    input  wire logic [7:0]                  ADV_VALUE,
    output logic [POS_W-1:0]                 POS_READ,
    output logic                             POS_VALID,
    output logic [15:0]                      HW_OUT,
    output logic [7:0]                       SW_FLAG,
    output logic [3:0]                       SW_IRQ
);
    localparam int HW  = pls_pkg::HW_OUTS;
    localparam int ADV = pls_pkg::ADV_OUTS;
    localparam int SW  = pls_pkg::SW_OUTS;
    localparam int IW  = pls_pkg::INDEX_W;

    localparam int ADV_W_L = pls_pkg::ADV_W;

    initial begin
        if (POS_W < 14 || POS_W > 24) $error("pls_controller: POS_W must be 14..24");
        if (pls_pkg::TABLE_DEPTH != (1 << IW)) $error("pls_controller: table depth must be a power of the index");
        if (HW + SW != 24) $error("pls_controller: a table entry must be 24 bits wide");
        if (ADV > HW || pls_pkg::IRQ_OUTS > SW) $error("pls_controller: output split does not fit");
    end

    logic [POS_W-1:0]     cycle_len;
    logic [POS_W-1:0]     pos;
    logic [HW+SW-1:0]     table_mem [pls_pkg::TABLE_DEPTH];
    logic [HW+SW-1:0]     entry;
    logic [IW-1:0]        index;
    logic                 scale_done;
    wire                  scale_start;
    logic [ADV_W_L-1:0]   adv [ADV];
    logic [POS_W-1:0]     scaled_pos;
    logic [POS_W-1:0]     scaled_len;
    pls_pkg::look_state_t look_state;
    pls_pkg::look_state_t next_look_state;

    // Source selection between the two angle buses.
    wire                     sel_strobe = BUS_SELECT ? ANGLE_STROBE_B : ANGLE_STROBE_A; // RQ2
    wire signed [15:0]       sel_delta  = BUS_SELECT ? ANGLE_DELTA_B : ANGLE_DELTA_A;   // RQ2
    wire signed [POS_W+1:0]  delta_ext  = (POS_W+2)'(sel_delta);
    wire signed [POS_W+1:0]  sum        = $signed({2'b00, pos}) + delta_ext; // RQ1
    wire signed [POS_W+1:0]  len_s      = $signed({2'b00, cycle_len});

    // Wrap both ways so reverse motion also lands inside one cycle.
    wire [POS_W-1:0] next_pos =
        (sum >= len_s)         ? POS_W'(sum - len_s) :  // RQ11
        (sum < 0)              ? POS_W'(sum + len_s) :  // RQ11
                                 POS_W'(sum);           // RQ1

    // Settings: cycle length; a zero value is ignored.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cycle_len <= POS_W'(pls_pkg::CYCLE_RESET);
        end else if (SET_CYCLE && CYCLE_VALUE != '0) begin
            cycle_len <= CYCLE_VALUE; // RQ3
        end
    end

    // Accumulator; a preset overrides any motion in the same cycle.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pos <= POS_W'(pls_pkg::POS_RESET);
        end else if (PRESET) begin
            pos <= (PRESET_VALUE < cycle_len) ? PRESET_VALUE : '0; // RQ7
        end else if (SET_CYCLE && CYCLE_VALUE != '0 && pos >= CYCLE_VALUE) begin
            pos <= '0; // RQ3
        end else if (sel_strobe) begin
            pos <= next_pos; // RQ1
        end
    end

    // Readback takes a copy only; the accumulator is untouched.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            POS_READ  <= '0;
            POS_VALID <= 1'b0;
        end else begin
            POS_VALID <= READ_POS; // RQ8
            if (READ_POS) begin
                POS_READ <= pos; // RQ8
            end
        end
    end

    // Switching table: bit i of an entry is output i within the on..off span.
    always_ff @(posedge CLK_SYS) begin
        if (TABLE_WRITE) begin
            table_mem[TABLE_ADDR] <= TABLE_DATA; // RQ5 RQ6
        end
        entry <= table_mem[index]; // RQ5
    end

    // Recompute the index only when the position or the cycle length moved since the
    // last look-up. A full pass takes about IW+3 cycles, far inside the reaction bound.
    wire stale = (pos != scaled_pos) || (cycle_len != scaled_len);
    assign scale_start = (look_state == pls_pkg::S_IDLE) && stale; // RQ15

    always_comb begin
        next_look_state = look_state;
        case (look_state)
            pls_pkg::S_IDLE: begin
                if (stale) begin
                    next_look_state = pls_pkg::S_SCALE;
                end
            end
            pls_pkg::S_SCALE: begin
                if (scale_done) begin
                    next_look_state = pls_pkg::S_LOOK;
                end
            end
            pls_pkg::S_LOOK: begin
                next_look_state = pls_pkg::S_IDLE;
            end
            default: begin
                next_look_state = pls_pkg::S_IDLE;
            end
        endcase
    end

    // The snapshot is taken with the divider's operands, so stale falls as soon
    // as a look-up starts, some IW cycles before its index is on hand.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            look_state <= pls_pkg::S_IDLE;
            scaled_pos <= '0;
            scaled_len <= '0;
        end else begin
            look_state <= next_look_state;
            if (scale_start) begin
                scaled_pos <= pos;
                scaled_len <= cycle_len;
            end
        end
    end

    pls_scaler #(
        .POS_W   (POS_W),
        .INDEX_W (IW)
    ) u_scaler (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .start     (scale_start),
        .pos       (pos),
        .cycle_len (cycle_len),
        .done      (scale_done),
        .index     (index)        // RQ15
    );

    // Velocity estimate in table steps per 10 ms window, for time advance.
    localparam int VEL_CYC = pls_pkg::VEL_PERIOD_CYC;
    localparam int STEP_CYC = pls_pkg::ADV_STEP_CYC;
    logic [IW-1:0] velocity;
    logic [IW-1:0] vel_count;
    logic [IW-1:0] last_index;
    logic [19:0]   vel_timer;
    wire  [IW-1:0] index_step = index - last_index;
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            velocity   <= '0;
            vel_count  <= '0;
            last_index <= '0;
            vel_timer  <= '0;
        end else begin
            if (scale_done) begin
                last_index <= index;
                vel_count  <= vel_count + index_step;
            end
            if (vel_timer == 20'(VEL_CYC - 1)) begin
                vel_timer <= '0;
                velocity  <= vel_count; // RQ14
                vel_count <= '0;
            end else begin
                vel_timer <= vel_timer + 20'h00001;
            end
        end
    end

    // Advance set: each count is 10 ms, so 255 gives 2.55 s.
    genvar g;
    generate
        for (g = 0; g < ADV; g++) begin : g_adv_set
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    adv[g] <= '0;
                end else if (ADV_WRITE && ADV_SEL == 3'(g)) begin
                    adv[g] <= ADV_VALUE; // RQ12
                end
            end
        end
    endgenerate

    // Look-ahead entries for the advanced outputs, one port per output.
    wire  [ADV-1:0] adv_state;
    generate
        for (g = 0; g < ADV; g++) begin : g_adv
            wire [21:0] lead = 22'(velocity) * 22'(adv[g]);
            wire [IW-1:0] ahead = index + IW'(lead);
            logic [HW+SW-1:0] ahead_entry;
            always_ff @(posedge CLK_SYS) begin
                ahead_entry <= table_mem[ahead];
            end
            assign adv_state[g] = (adv[g] == '0) ? entry[g] : ahead_entry[g]; // RQ12 RQ13
        end
    endgenerate

    // Bits below ADV may run ahead of the position; the rest follow the entry.
    wire [HW-1:0] next_hw;
    generate
        for (g = 0; g < HW; g++) begin : g_hw
            if (g < ADV) begin : g_lead
                assign next_hw[g] = adv_state[g]; // RQ12
            end else begin : g_plain
                assign next_hw[g] = entry[g]; // RQ6
            end
        end
    endgenerate

    // Outputs are registered each clock, well within the 1.5 ms reaction time.
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            HW_OUT      <= '0;
        end else begin
            HW_OUT      <= next_hw; // RQ9 RQ13 RQ14
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            SW_FLAG     <= '0;
            SW_IRQ      <= '0;
        end else begin
            SW_FLAG     <= entry[HW+SW-1:HW];           // RQ10
            // Interrupt pulses on the rising edge of the first four flags.
            SW_IRQ      <= entry[HW+3:HW] & ~SW_FLAG[3:0]; // RQ10
        end
    end
endmodule // pls_controller
`default_nettype wire

// *** verilog/pls_pkg.sv ***
// Package of constants and types for the programmable limit switch.
package pls_pkg;
    localparam int    POS_W          = 24;
    localparam int    TABLE_DEPTH    = 8192;
    localparam int    INDEX_W        = 13;
    localparam int    HW_OUTS        = 16;
    localparam int    ADV_OUTS       = 8;
    localparam int    SW_OUTS        = 8;
    localparam int    IRQ_OUTS       = 4;
    localparam int    ADV_W          = 8;
    localparam int    CLK_HZ         = 100_000_000;
    localparam int    ADV_STEP_MS    = 10;
    localparam int    ADV_STEP_CYC   = CLK_HZ / 1000 * ADV_STEP_MS;
    localparam int    REACT_US       = 1500;
    localparam int    REACT_CYC      = CLK_HZ / 1_000_000 * REACT_US;
    localparam int    VEL_PERIOD_MS  = 10;
    localparam int    VEL_PERIOD_CYC = CLK_HZ / 1000 * VEL_PERIOD_MS;
    localparam logic [23:0] CYCLE_RESET = 24'h002000;
    localparam logic [23:0] POS_RESET   = 24'h000000;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_SCALE = 3'b010,
        S_LOOK  = 3'b100
    } look_state_t;
endpackage : pls_pkg

// *** verilog/pls_scaler.sv ***
// Scales an accumulator value into a switching table index.
`timescale 1ns/100ps
`default_nettype none
module pls_scaler #(
    parameter int POS_W   = 24,
    parameter int INDEX_W = 13
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               start,
    input  wire logic [POS_W-1:0]   pos,
    input  wire logic [POS_W-1:0]   cycle_len,
    output logic                    done,
    output logic [INDEX_W-1:0]      index
);
    // Restoring division of pos * 2^INDEX_W by cycle_len, one quotient bit per clock.
    localparam int NUM_W = POS_W + INDEX_W;
    initial begin
        if (POS_W < 2 || INDEX_W < 1) $error("pls_scaler: bad widths");
    end
    logic [NUM_W-1:0] rem;
    logic [NUM_W-1:0] divisor;
    logic [INDEX_W:0] quo;
    logic [5:0]       bitn;
    logic             busy;
    wire  [NUM_W-1:0] shifted = {rem[NUM_W-2:0], 1'b0};
    wire              fits    = shifted >= divisor;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rem     <= '0;
            divisor <= '0;
            quo     <= '0;
            bitn    <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
            index   <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem     <= {{INDEX_W{1'b0}}, pos};
                divisor <= {{INDEX_W{1'b0}}, cycle_len};
                quo     <= '0;
                bitn    <= 6'(INDEX_W);
                busy    <= 1'b1;
            end else if (busy) begin
                rem  <= fits ? shifted - divisor : shifted;
                quo  <= {quo[INDEX_W-1:0], fits};
                bitn <= bitn - 6'h01;
                if (bitn == 6'h01) begin
                    busy  <= 1'b0;
                    done  <= 1'b1;
                    index <= {quo[INDEX_W-2:0], fits};
                end
            end
        end
    end
endmodule // pls_scaler
`default_nettype wire
